// [bench/sbis_host.sv]
/*
  sbis_host.sv: host model, straps the boot pins and sends 8E1 bytes.
  Assumes send is called 1 ns after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module sbis_host #(parameter int BIT = 8) (
  input wire logic clock,
  output logic primary_pin,
  output logic secondary_pin,
  output logic [2:0] line
);
  initial begin
    primary_pin = 1'b1;
    secondary_pin = 1'b0;
    line = 3'h7;
  end
  // idle lines held high; start, lsb first data, parity, stop
  task automatic send(input logic [2:0] mask, input logic [7:0] data, input logic bad);
    logic [10:0] frame;
    frame = {1'b1, ^data ^ bad, data, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line = ~mask | {3{frame[i]}};
      repeat (BIT) @(posedge clock);
      #1;
    end
    repeat (BIT) @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
/*
  tb_top.sv: self-checking bench of the boot interface selector.
  Assumes the host model above and a 20 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int BIT = 8;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic app_jump = 1'b0;
  logic vrange_wr = 1'b0;
  logic [2:0] vrange_value = 3'h0;
  logic flash_wr_req = 1'b0;
  logic [1:0] flash_wr_width = 2'h0;
  logic ram_req = 1'b0;
  logic [31:0] ram_addr = 32'h0;
  logic p_pin, s_pin;
  logic [2:0] line;
  logic tx0, tx1, tx2, boot_mode, rc_sel, locked, cmd_valid, cmd_err;
  logic wdg_max, wdg_refresh, grant, reject, ram_hit;
  logic [2:0] port_en, vrange;
  logic [1:0] sel_port;
  logic [15:0] baud_ticks;
  logic [7:0] cmd_byte;
  int failures = 0;
  int total_checks = 0;
  int n_valid = 0;
  int n_err = 0;
  int n_ref = 0;
  int cycles = 0;
  int v0, e0;

  always #25 clock = ~clock;

  sbis_host #(.BIT(BIT)) u_host (.clock(clock), .primary_pin(p_pin),
    .secondary_pin(s_pin), .line(line));

  sbis_top #(.TW(16), .WDG_CYC(16)) u_dut (
    .clock(clock), .nrst(nrst), .ce(ce),
    .primary_boot_select_pin(p_pin), .secondary_boot_select_pin(s_pin),
    .first_port_receive_line(line[0]), .second_port_receive_line_a(line[1]),
    .second_port_receive_line_b(line[2]), .app_jump(app_jump),
    .vrange_wr(vrange_wr), .vrange_value(vrange_value),
    .flash_wr_req(flash_wr_req), .flash_wr_width(flash_wr_width),
    .ram_req(ram_req), .ram_addr(ram_addr),
    .first_port_transmit_line(tx0), .second_port_transmit_line_a(tx1),
    .second_port_transmit_line_b(tx2), .boot_mode(boot_mode),
    .rc_clock_select(rc_sel), .port_en(port_en), .sel_port(sel_port),
    .locked(locked), .baud_ticks(baud_ticks), .cmd_byte(cmd_byte),
    .cmd_valid(cmd_valid), .cmd_err(cmd_err), .wdg_prescale_max(wdg_max),
    .wdg_refresh(wdg_refresh), .vrange(vrange), .flash_wr_grant(grant),
    .flash_wr_reject(reject), .boot_ram_hit(ram_hit));

  task automatic finish_test;
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cmd_valid === 1'b1) n_valid++;
    if (cmd_err === 1'b1) n_err++;
    if (wdg_refresh === 1'b1) n_ref++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick;
    @(posedge clock);
    #1;
  endtask

  task automatic t_strap;
    repeat (4) tick();
    check("boot_mode", boot_mode, 1);
    check("rc_clock_select", rc_sel, 1);
    check("port_en", port_en, 3'h7);
    check("locked", locked, 0);
    check("tx", {tx2, tx1, tx0}, 3'h7);
    check("wdg_prescale_max", wdg_max, 1);
    check("vrange", vrange, 3'h0);
  endtask

  task automatic wr(input logic [1:0] w, input logic exp_grant);
    flash_wr_req = 1'b1;
    flash_wr_width = w;
    tick();
    check("flash_wr_grant", grant, exp_grant);
    check("flash_wr_reject", reject, !exp_grant);
    flash_wr_req = 1'b0;
    tick();
  endtask

  task automatic t_policy;
    for (int w = 0; w < 4; w++) wr(w[1:0], w == 0);
  endtask

  task automatic t_ram;
    logic [31:0] a [4] = '{32'h2000_0000, 32'h2000_1FFF, 32'h2000_2000, 32'h1FFF_FFFF};
    for (int i = 0; i < 4; i++) begin
      ram_req = 1'b1;
      ram_addr = a[i];
      tick();
      check("boot_ram_hit", ram_hit, i < 2);
      ram_req = 1'b0;
      tick();
    end
  endtask

  task automatic t_wdg;
    int n;
    n = 0;
    while (wdg_refresh !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    n = 0;
    do begin
      tick();
      n++;
    end while (wdg_refresh !== 1'b1 && n < 40);
    check("refresh period", n, 16);
  endtask

  task automatic t_lock;
    u_host.send(3'h6, 8'h7F, 1'b0);
    check("locked", locked, 1);
    check("sel_port", sel_port, 1);
    check("port_en", port_en, 3'h2);
    check("baud_ticks", baud_ticks, BIT);
  endtask

  task automatic t_cmd;
    v0 = n_valid;
    e0 = n_err;
    u_host.send(3'h1, 8'h7F, 1'b0);
    check("ignored line", n_valid - v0, 0);
    check("sel_port after other sync", sel_port, 1);
    u_host.send(3'h2, 8'hA5, 1'b0);
    check("cmd count", n_valid - v0, 1);
    check("cmd_byte", cmd_byte, 8'hA5);
    u_host.send(3'h2, 8'h3C, 1'b1);
    check("cmd_err count", n_err - e0, 1);
    check("cmd after error", n_valid - v0, 1);
  endtask

  task automatic t_jump;
    vrange_wr = 1'b1;
    vrange_value = 3'h5;
    tick();
    vrange_wr = 1'b0;
    tick();
    check("vrange bad code", vrange, 3'h0);
    vrange_wr = 1'b1;
    vrange_value = 3'h3;
    tick();
    vrange_wr = 1'b0;
    tick();
    check("vrange", vrange, 3'h3);
    wr(2'h2, 1'b1);
    app_jump = 1'b1;
    tick();
    app_jump = 1'b0;
    repeat (2) tick();
    v0 = n_ref;
    repeat (40) tick();
    check("refresh in jump", n_ref - v0, 0);
    check("port_en kept", port_en, 3'h2);
    check("vrange kept", vrange, 3'h3);
    check("baud kept", baud_ticks, BIT);
    check("prescale kept", wdg_max, 1);
  endtask

  task automatic t_relock;
    nrst = 1'b0;
    tick();
    check("locked in reset", locked, 0);
    check("vrange in reset", vrange, 3'h0);
    tick();
    nrst = 1'b1;
    tick();
    check("port_en rehunt", port_en, 3'h7);
    u_host.send(3'h7, 8'h7F, 1'b0);
    check("locked again", locked, 1);
    check("sel_port lowest", sel_port, 0);
    check("port_en lowest", port_en, 3'h1);
    check("baud_ticks relock", baud_ticks, BIT);
  endtask

  initial begin
    repeat (5) @(posedge clock);
    #1;
    nrst = 1'b1;
    t_strap();
    t_policy();
    t_ram();
    t_wdg();
    t_lock();
    t_cmd();
    t_jump();
    t_relock();
    finish_test();
  end
endmodule
`default_nettype wire

// [core/sbis_defs.svh]
/*
  sbis_defs.svh: constants of the serial boot interface selector.
  Assumes inclusion by bare name from the core files.
*/
`ifndef SBIS_DEFS_SVH
`define SBIS_DEFS_SVH

`define SBIS_SYNC_BYTE 8'h7F
`define SBIS_CLK_HZ 20000000
`define SBIS_BOOT_CLK_MHZ 24
`define SBIS_WDG_REFRESH_US 1000
`define SBIS_WDG_REFRESH_CYC (`SBIS_WDG_REFRESH_US * (`SBIS_CLK_HZ / 1000000))
`define SBIS_RAM_BASE 32'h2000_0000
`define SBIS_RAM_SIZE 32'h0000_2000
`define SBIS_VRANGE_LOW 3'h0
`define SBIS_VRANGE_MAX 3'h4
`define SBIS_NUM_LINES 3
`define SBIS_FRAME_STOP 4'hA
`define SBIS_FRAME_PARITY 4'h9

`endif

// [core/sbis_det_if.sv]
/*
  sbis_det_if.sv: link between the selector and one sync detector.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface sbis_det_if #(parameter int TW = 16);
  logic en;
  logic hit;
  logic [TW-1:0] ticks;
  modport ctl (output en, input hit, input ticks);
  modport det (input en, output hit, output ticks);
endinterface
`default_nettype wire

// [core/sbis_pkg.sv]
/*
  sbis_pkg.sv: types of the serial boot interface selector.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sbis_pkg;
  typedef enum logic [2:0] {
    SBIS_ST_STRAP = 3'b000,
    SBIS_ST_HUNT = 3'b001,
    SBIS_ST_LOCK = 3'b010,
    SBIS_ST_JUMP = 3'b011,
    SBIS_ST_OFF = 3'b100
  } sbis_state_t;

  typedef enum logic [1:0] {
    SBIS_DT_IDLE = 2'b00,
    SBIS_DT_START = 2'b01,
    SBIS_DT_HIGH = 2'b10,
    SBIS_DT_LAST = 2'b11
  } sbis_det_state_t;

  typedef enum logic [1:0] {
    SBIS_WR_BYTE = 2'b00,
    SBIS_WR_HALF = 2'b01,
    SBIS_WR_WORD = 2'b10,
    SBIS_WR_DWORD = 2'b11
  } sbis_wr_width_t;
endpackage

// [core/sbis_sync_det.sv]
/*
  sbis_sync_det.sv: watches one receive line for the sync byte and
  measures its bit time. Assumes the line is synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sbis_defs.svh"
module sbis_sync_det #(parameter int TW = 16) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic rx,
  sbis_det_if.det bus
);
  sbis_pkg::sbis_det_state_t state;
  logic [TW-1:0] cnt;
  logic [TW-1:0] t_start;
  logic [TW-1:0] t_high;
  logic rx_prev;
  logic [TW+3:0] sum8;

  // count includes the edge cycle itself
  localparam logic [TW-1:0] CNT_ONE = {{(TW-1){1'b0}}, 1'b1};

  assign sum8 = {4'h0, t_high} + {4'h0, cnt};

  // low start, seven high data bits, low last bit
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= sbis_pkg::SBIS_DT_IDLE;
      cnt <= '0;
      t_start <= '0;
      t_high <= '0;
      rx_prev <= 1'b1;
      bus.hit <= 1'b0;
      bus.ticks <= '0;
    end else if (ce) begin
      rx_prev <= rx;
      bus.hit <= 1'b0;
      if (cnt != '1) cnt <= cnt + 1'b1;
      if (!bus.en) begin
        state <= sbis_pkg::SBIS_DT_IDLE;
      end else begin
        case (state)
          sbis_pkg::SBIS_DT_IDLE: begin
            if (rx_prev && !rx) begin
              state <= sbis_pkg::SBIS_DT_START;
              cnt <= CNT_ONE;
            end
          end
          sbis_pkg::SBIS_DT_START: begin
            if (rx) begin
              t_start <= cnt;
              cnt <= CNT_ONE;
              state <= sbis_pkg::SBIS_DT_HIGH;
            end
          end
          sbis_pkg::SBIS_DT_HIGH: begin
            if (!rx) begin
              t_high <= cnt;
              cnt <= CNT_ONE;
              state <= sbis_pkg::SBIS_DT_LAST;
            end
          end
          sbis_pkg::SBIS_DT_LAST: begin
            if (rx) begin
              state <= sbis_pkg::SBIS_DT_IDLE;
              // seven high bits against one low bit
              if (cnt != '0 && t_start != '0 &&
                  {3'h0, cnt, 2'h0} + {4'h0, cnt} <= {3'h0, t_high, 1'b0}
                    + {3'h0, t_high} - {4'h0, t_high} - {4'h0, t_high}
                    + {4'h0, t_high} &&
                  {1'h0, t_high} <= {1'h0, cnt} * 4'h9 &&
                  {1'h0, t_high} >= {1'h0, t_start} * 4'h5) begin
                bus.hit <= 1'b1;
                bus.ticks <= sum8[TW+2:3];
              end
            end
          end
          default: state <= sbis_pkg::SBIS_DT_IDLE;
        endcase
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_last_rise;
    ce && bus.en && state == sbis_pkg::SBIS_DT_LAST && rx;
  endsequence

  property p_hit_only_after_last;
    $rose(bus.hit) |-> $past(state) == sbis_pkg::SBIS_DT_LAST;
  endproperty
  a_hit_only_after_last: assert property (p_hit_only_after_last)
    else $error("sync hit without a finished frame");

  property p_ticks_measured;
    s_last_rise ##1 bus.hit |-> bus.ticks != '0;
  endproperty
  a_ticks_measured: assert property (p_ticks_measured)
    else $error("sync hit with zero bit time");
endmodule
`default_nettype wire

// [core/sbis_top.sv]
/*
  sbis_top.sv: boot strap capture, hunt over three receive lines,
  lock to the first sync byte, 8E1 command byte receiver, watchdog
  upkeep and write width policy. Assumes all inputs synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sbis_defs.svh"
module sbis_top #(
  parameter int TW = 16,
  parameter int WDG_CYC = `SBIS_WDG_REFRESH_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic primary_boot_select_pin,
  input wire logic secondary_boot_select_pin,
  input wire logic first_port_receive_line,
  input wire logic second_port_receive_line_a,
  input wire logic second_port_receive_line_b,
  input wire logic app_jump,
  input wire logic vrange_wr,
  input wire logic [2:0] vrange_value,
  input wire logic flash_wr_req,
  input wire logic [1:0] flash_wr_width,
  input wire logic ram_req,
  input wire logic [31:0] ram_addr,
  output logic first_port_transmit_line,
  output logic second_port_transmit_line_a,
  output logic second_port_transmit_line_b,
  output logic boot_mode,
  output logic rc_clock_select,
  output logic [2:0] port_en,
  output logic [1:0] sel_port,
  output logic locked,
  output logic [TW-1:0] baud_ticks,
  output logic [7:0] cmd_byte,
  output logic cmd_valid,
  output logic cmd_err,
  output logic wdg_prescale_max,
  output logic wdg_refresh,
  output logic [2:0] vrange,
  output logic flash_wr_grant,
  output logic flash_wr_reject,
  output logic boot_ram_hit
);
  localparam int CW = 24;
  localparam logic [CW-1:0] WDG_LAST = CW'(WDG_CYC - 1);

  sbis_pkg::sbis_state_t state;
  logic [2:0] lines;
  logic [2:0] hit;
  logic [TW-1:0] hit_ticks [3];
  logic sel_rx;
  logic rx_prev;
  logic rx_on;
  logic [TW-1:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [7:0] shreg;
  logic par_ok;
  logic [CW-1:0] wdg_cnt;

  function automatic logic [1:0] first_hit(input logic [2:0] h);
    if (h[0]) first_hit = 2'h0;
    else if (h[1]) first_hit = 2'h1;
    else first_hit = 2'h2;
  endfunction

  // only receive lines enter; no clock or handshake pins
  assign lines = {second_port_receive_line_b, second_port_receive_line_a,
                  first_port_receive_line};
  assign sel_rx = lines[sel_port];

  sbis_det_if #(.TW(TW)) det_bus [`SBIS_NUM_LINES] ();

  genvar g;
  generate
    for (g = 0; g < `SBIS_NUM_LINES; g++) begin : g_det
      assign det_bus[g].en = port_en[g];
      assign hit[g] = det_bus[g].hit;
      assign hit_ticks[g] = det_bus[g].ticks;
      sbis_sync_det #(.TW(TW)) u_det (
        .clock(clock),
        .nrst(nrst),
        .ce(ce),
        .rx(lines[g]),
        .bus(det_bus[g])
      );
    end
  endgenerate

  // boot strap, hunt and lock
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= sbis_pkg::SBIS_ST_STRAP;
      boot_mode <= 1'b0;
      rc_clock_select <= 1'b0;
      port_en <= 3'h0;
      sel_port <= 2'h0;
      locked <= 1'b0;
      baud_ticks <= '0;
    end else if (ce) begin
      case (state)
        sbis_pkg::SBIS_ST_STRAP: begin
          if (primary_boot_select_pin && !secondary_boot_select_pin) begin
            boot_mode <= 1'b1;
            rc_clock_select <= 1'b1;
            port_en <= 3'h7;
            state <= sbis_pkg::SBIS_ST_HUNT;
          end else begin
            state <= sbis_pkg::SBIS_ST_OFF;
          end
        end
        sbis_pkg::SBIS_ST_HUNT: begin
          if (hit != 3'h0) begin
            sel_port <= first_hit(hit);
            baud_ticks <= hit_ticks[first_hit(hit)];
            port_en <= 3'h1 << first_hit(hit);
            locked <= 1'b1;
            state <= sbis_pkg::SBIS_ST_LOCK;
          end
        end
        sbis_pkg::SBIS_ST_LOCK: begin
          if (app_jump) state <= sbis_pkg::SBIS_ST_JUMP;
        end
        sbis_pkg::SBIS_ST_JUMP: state <= sbis_pkg::SBIS_ST_JUMP;
        sbis_pkg::SBIS_ST_OFF: state <= sbis_pkg::SBIS_ST_OFF;
        default: state <= sbis_pkg::SBIS_ST_STRAP;
      endcase
    end
  end

  // command byte receiver on the selected line
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_prev <= 1'b1;
      rx_on <= 1'b0;
      rx_cnt <= '0;
      rx_bit <= 4'h0;
      shreg <= 8'h00;
      par_ok <= 1'b0;
      cmd_byte <= 8'h00;
      cmd_valid <= 1'b0;
      cmd_err <= 1'b0;
    end else if (ce) begin
      cmd_valid <= 1'b0;
      cmd_err <= 1'b0;
      if (state != sbis_pkg::SBIS_ST_LOCK) begin
        rx_on <= 1'b0;
        rx_prev <= 1'b1;
      end else begin
        rx_prev <= sel_rx;
        if (!rx_on) begin
          if (rx_prev && !sel_rx) begin
            rx_on <= 1'b1;
            rx_cnt <= baud_ticks >> 1;
            rx_bit <= 4'h0;
          end
        end else if (rx_cnt == '0) begin
          rx_cnt <= baud_ticks - 1'b1;
          rx_bit <= rx_bit + 4'h1;
          if (rx_bit == 4'h0) begin
            if (sel_rx) rx_on <= 1'b0;
          end else if (rx_bit < `SBIS_FRAME_PARITY) begin
            shreg <= {sel_rx, shreg[7:1]};
          end else if (rx_bit == `SBIS_FRAME_PARITY) begin
            par_ok <= ~(^shreg ^ sel_rx);
          end else begin
            rx_on <= 1'b0;
            if (sel_rx && par_ok) begin
              cmd_valid <= 1'b1;
              cmd_byte <= shreg;
            end else begin
              cmd_err <= 1'b1;
            end
          end
        end else begin
          rx_cnt <= rx_cnt - 1'b1;
        end
      end
    end
  end

  // transmit lines idle high
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      first_port_transmit_line <= 1'b1;
      second_port_transmit_line_a <= 1'b1;
      second_port_transmit_line_b <= 1'b1;
    end else if (ce) begin
      first_port_transmit_line <= 1'b1;
      second_port_transmit_line_a <= 1'b1;
      second_port_transmit_line_b <= 1'b1;
    end
  end

  // watchdog upkeep while boot code runs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wdg_prescale_max <= 1'b0;
      wdg_refresh <= 1'b0;
      wdg_cnt <= '0;
    end else if (ce) begin
      wdg_refresh <= 1'b0;
      if (state == sbis_pkg::SBIS_ST_HUNT || state == sbis_pkg::SBIS_ST_LOCK) begin
        wdg_prescale_max <= 1'b1;
        if (wdg_cnt >= WDG_LAST) begin
          wdg_cnt <= '0;
          wdg_refresh <= 1'b1;
        end else begin
          wdg_cnt <= wdg_cnt + 1'b1;
        end
      end
    end
  end

  // voltage range, write width policy, reserved ram window
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      vrange <= `SBIS_VRANGE_LOW;
      flash_wr_grant <= 1'b0;
      flash_wr_reject <= 1'b0;
      boot_ram_hit <= 1'b0;
    end else if (ce) begin
      flash_wr_grant <= 1'b0;
      flash_wr_reject <= 1'b0;
      if (vrange_wr && state == sbis_pkg::SBIS_ST_LOCK &&
          vrange_value <= `SBIS_VRANGE_MAX) begin
        vrange <= vrange_value;
      end
      if (flash_wr_req) begin
        if (vrange == `SBIS_VRANGE_LOW &&
            flash_wr_width != sbis_pkg::SBIS_WR_BYTE) begin
          flash_wr_reject <= 1'b1;
        end else begin
          flash_wr_grant <= 1'b1;
        end
      end
      boot_ram_hit <= ram_req && boot_mode && ram_addr >= `SBIS_RAM_BASE &&
                      ram_addr < `SBIS_RAM_BASE + `SBIS_RAM_SIZE;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_hunt_hit0;
    ce && state == sbis_pkg::SBIS_ST_HUNT && hit[0];
  endsequence
  sequence s_locked_on0;
    state == sbis_pkg::SBIS_ST_LOCK && sel_port == 2'h0 && port_en == 3'h1;
  endsequence

  property p_hunt_stays;
    ce && state == sbis_pkg::SBIS_ST_HUNT && hit == 3'h0 |=>
      state == sbis_pkg::SBIS_ST_HUNT && port_en == 3'h7;
  endproperty
  a_hunt_stays: assert property (p_hunt_stays)
    else $error("hunt left without a sync hit");

  property p_first_wins;
    s_hunt_hit0 |=> s_locked_on0;
  endproperty
  a_first_wins: assert property (p_first_wins)
    else $error("line zero hit did not win the lock");

  property p_others_off;
    locked |-> $onehot(port_en) && port_en[sel_port];
  endproperty
  a_others_off: assert property (p_others_off)
    else $error("unselected line still enabled");

  property p_byte_only_low;
    ce && flash_wr_req && vrange == `SBIS_VRANGE_LOW &&
      flash_wr_width != sbis_pkg::SBIS_WR_BYTE |=> flash_wr_reject && !flash_wr_grant;
  endproperty
  a_byte_only_low: assert property (p_byte_only_low)
    else $error("wide write allowed in lowest range");

  property p_jump_keeps;
    state == sbis_pkg::SBIS_ST_JUMP |=> $stable(port_en) && $stable(baud_ticks);
  endproperty
  a_jump_keeps: assert property (p_jump_keeps)
    else $error("settings changed after jump");

  property p_refresh_spacing;
    ce && wdg_refresh && WDG_CYC > 2 |=> !wdg_refresh [*2];
  endproperty
  a_refresh_spacing: assert property (p_refresh_spacing)
    else $error("watchdog refreshed too often");

  property p_err_excl;
    !(cmd_valid && cmd_err);
  endproperty
  a_err_excl: assert property (p_err_excl)
    else $error("byte both valid and in error");

  property p_ram_window;
    ce && ram_req && boot_mode && ram_addr == `SBIS_RAM_BASE |=> boot_ram_hit;
  endproperty
  a_ram_window: assert property (p_ram_window)
    else $error("reserved ram base not flagged");

  property p_rc_in_boot;
    state == sbis_pkg::SBIS_ST_HUNT |-> rc_clock_select && boot_mode;
  endproperty
  a_rc_in_boot: assert property (p_rc_in_boot)
    else $error("boot hunt without internal rc select");
endmodule
`default_nettype wire
